// [logic/cvf_pkg.sv]
// package: register map, field layout, decode tables and timing for the cell voltage fault block
`default_nettype none
package cvf_pkg;
   // register offsets (byte addresses on the plain register port)
   localparam logic [7:0] ADDR_SYS_CFG = 8'h01;
   localparam logic [7:0] ADDR_OV_TRIP = 8'h02;
   localparam logic [7:0] ADDR_OV_CFG = 8'h03;
   localparam logic [7:0] ADDR_UV_TRIP = 8'h04;
   localparam logic [7:0] ADDR_UNDERVOLTAGE_RECOVERY_MODE = 8'h05;
   localparam logic [7:0] ADDR_OCD_DLY = 8'h06;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // reset values
   localparam logic [7:0] RST_SYS_CFG = 8'h00;
   localparam logic [7:0] RST_OV_TRIP = 8'h38;
   localparam logic [7:0] RST_OV_CFG = 8'h00;
   localparam logic [7:0] RST_UV_TRIP = 8'h00;
   localparam logic [7:0] RST_UNDERVOLTAGE_RECOVERY_MODE = 8'h00;
   localparam logic [7:0] RST_OCD_DLY = 8'h08;
   // field positions
   localparam int CNT_LSB = 5;
   localparam int OVT_LSB = 0;
   localparam int TS_CTL_BIT = 7;
   localparam int OVH_LSB = 4;
   localparam int OVD_LSB = 0;
   localparam int UV_INH_BIT = 7;
   localparam int UVT_LSB = 0;
   localparam int UV_RECMODE_BIT = 7;
   localparam int UV_SD_BIT = 6;
   localparam int UVH_LSB = 4;
   localparam int UVD_LSB = 0;
   localparam int DISCHARGE_OVERCURRENT_DELAY_CODE_W = 5;
   localparam logic [2:0] UVD_OFF = 3'h7;
   localparam logic [2:0] CNT_CODE_BAD = 3'h7;
   // voltages in millivolts
   localparam int MV_W = 13;
   localparam int MAX_CELLS = 10;
   localparam int MIN_CELLS = 4;
   localparam logic [MV_W-1:0] OV_TRIP_BASE_MV = 13'h0AF0;
   localparam logic [MV_W-1:0] OV_TRIP_STEP_MV = 13'h0019;
   localparam logic [MV_W-1:0] UV_TRIP_BASE_MV = 13'h0578;
   localparam logic [MV_W-1:0] UV_TRIP_STEP_MV = 13'h0064;
   localparam logic [MV_W-1:0] UV_HYST_STEP_MV = 13'h0190;
   localparam logic [MV_W-1:0] UNDERVOLTAGE_RECOVERY_MODE_MAX_MV = 13'h0DAC;
   // ov hysteresis by code, index 0 = 300 mV ... index 7 = 0 mV
   localparam logic [7:0][MV_W-1:0] OV_HYST_MV = {13'h0000, 13'h0019, 13'h0032, 13'h0064,
                                                  13'h0096, 13'h00C8, 13'h00FA, 13'h012C};
   // timing: one tick every 250 ms
   localparam int CLK_KHZ = 10000;
   localparam int TICK_MS = 250;
   localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
   localparam int OV_DLY_BASE_MS = 500;
   localparam int UV_DLY_BASE_MS = 500;
   localparam int SD_HOLD_MS = 8000;
   localparam int OV_DLY_BASE_TICKS = OV_DLY_BASE_MS / TICK_MS;
   localparam int UV_DLY_BASE_TICKS = UV_DLY_BASE_MS / TICK_MS;
   localparam int SD_HOLD_TICKS = SD_HOLD_MS / TICK_MS;

   typedef enum logic [2:0] {
      CVF_UV_NORMAL = 3'b001,
      CVF_UV_FAULT = 3'b010,
      CVF_UV_SHUTDOWN = 3'b100
   } cvf_uv_state_t;

   typedef struct packed {
      logic charger_present;
      logic load_present;
   } cvf_pins_t;

   typedef logic [MAX_CELLS-1:0][MV_W-1:0] cvf_cells_t;
endpackage
`default_nettype wire

// [logic/cvf_top.sv]
// cell voltage fault configuration, decode and fault timing
// Function
// - thermistor charger-control bit set: pull thermistor line low on overvoltage fault
// - ov hysteresis code selects 300..50 mV, then 25 mV, then 0 mV
// - ov delay code selects 0.5 s to 2.25 s in 0.25 s steps
// - hysteresis-inhibit clear uses trip plus hysteresis for recovery; set uses trip only
// - uv trip code selects 1.4 V to 2.9 V in 0.1 V steps
// - recovery mode clear: recover when all cells above level; charge on immediately
// - recovery mode set: recover only when all cells above level and load removed
// - shutdown-enable clear: never enter shutdown from undervoltage fault
// - shutdown-enable set: shutdown if any cell below level over 8 s in fault
// - uv hysteresis code selects 0.4, 0.8, 1.2 or 1.6 V
// - uv recovery level clamped to at most 3.5 V
// - uv delay code selects 0.5 s to 32 s binary; code 7 disables detection
// - discharge overcurrent delay register uses low five bits; upper three unused
// - ov trip code selects 2.8 V to 4.375 V in 25 mV steps
// - cell count code selects 10 down to 4 cells; only those cells checked
`default_nettype none
module cvf_top #(
   parameter int TICK_CYCLES = cvf_pkg::TICK_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire cvf_pkg::cvf_cells_t i_cell_mv,
   input wire cvf_pkg::cvf_pins_t i_pins,
   output logic [7:0] o_rdata,
   output logic o_ov_fault,
   output logic o_uv_fault,
   output logic o_shutdown,
   output logic o_chg_fet_en,
   output logic o_dsg_fet_en,
   output logic o_therm_out,
   output logic o_therm_oe,
   output logic [cvf_pkg::DISCHARGE_OVERCURRENT_DELAY_CODE_W-1:0] o_discharge_overcurrent_delay_code
);
   localparam int MV_W = cvf_pkg::MV_W;
   localparam int NC = cvf_pkg::MAX_CELLS;

   logic [7:0] sys_cfg_ff, ov_trip_ff, ov_cfg_ff, uv_trip_ff, undervoltage_recovery_mode_ff, ocd_dly_ff;
   logic [7:0] rdata_ff, nxt_rdata;
   cvf_pkg::cvf_cells_t cell_s1_ff, cell_s2_ff;
   cvf_pkg::cvf_pins_t pin_s1_ff, pin_s2_ff;
   logic [23:0] tick_cnt_ff;
   logic tick_ff;
   logic [3:0] ov_cnt_ff;
   logic [7:0] uv_cnt_ff;
   logic [5:0] sd_cnt_ff;
   logic ov_fault_ff, therm_oe_ff, chg_ff, dsg_ff;
   cvf_pkg::cvf_uv_state_t uv_st_ff, nxt_uv_st;

   // register port
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         sys_cfg_ff <= cvf_pkg::RST_SYS_CFG;
         ov_trip_ff <= cvf_pkg::RST_OV_TRIP;
         ov_cfg_ff <= cvf_pkg::RST_OV_CFG;
         uv_trip_ff <= cvf_pkg::RST_UV_TRIP;
         undervoltage_recovery_mode_ff <= cvf_pkg::RST_UNDERVOLTAGE_RECOVERY_MODE;
         ocd_dly_ff <= cvf_pkg::RST_OCD_DLY;
      end else if (i_wr) begin
         case (i_addr)
            cvf_pkg::ADDR_SYS_CFG: sys_cfg_ff <= i_wdata;
            cvf_pkg::ADDR_OV_TRIP: ov_trip_ff <= {2'h0, i_wdata[5:0]};
            cvf_pkg::ADDR_OV_CFG: ov_cfg_ff <= {i_wdata[7:4], 1'h0, i_wdata[2:0]};
            cvf_pkg::ADDR_UV_TRIP: uv_trip_ff <= {i_wdata[7], 3'h0, i_wdata[3:0]};
            cvf_pkg::ADDR_UNDERVOLTAGE_RECOVERY_MODE: undervoltage_recovery_mode_ff <= {i_wdata[7:4], 1'h0, i_wdata[2:0]};
            cvf_pkg::ADDR_OCD_DLY: ocd_dly_ff <= {3'h0, i_wdata[4:0]};
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            cvf_pkg::ADDR_SYS_CFG: nxt_rdata = sys_cfg_ff;
            cvf_pkg::ADDR_OV_TRIP: nxt_rdata = ov_trip_ff;
            cvf_pkg::ADDR_OV_CFG: nxt_rdata = ov_cfg_ff;
            cvf_pkg::ADDR_UV_TRIP: nxt_rdata = uv_trip_ff;
            cvf_pkg::ADDR_UNDERVOLTAGE_RECOVERY_MODE: nxt_rdata = undervoltage_recovery_mode_ff;
            cvf_pkg::ADDR_OCD_DLY: nxt_rdata = ocd_dly_ff;
            cvf_pkg::ADDR_STATUS: nxt_rdata = {5'h00, o_shutdown, o_uv_fault, ov_fault_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // field decode
   wire logic [2:0] cnt_code = sys_cfg_ff[cvf_pkg::CNT_LSB +: 3];
   wire logic [5:0] ovt_code = ov_trip_ff[cvf_pkg::OVT_LSB +: 6];
   wire logic ts_ctl = ov_cfg_ff[cvf_pkg::TS_CTL_BIT];
   wire logic [2:0] ovh_code = ov_cfg_ff[cvf_pkg::OVH_LSB +: 3];
   wire logic [2:0] ovd_code = ov_cfg_ff[cvf_pkg::OVD_LSB +: 3];
   wire logic uv_inh = uv_trip_ff[cvf_pkg::UV_INH_BIT];
   wire logic [3:0] uvt_code = uv_trip_ff[cvf_pkg::UVT_LSB +: 4];
   wire logic undervoltage_recovery_mode_mode = undervoltage_recovery_mode_ff[cvf_pkg::UV_RECMODE_BIT];
   wire logic uv_sd_en = undervoltage_recovery_mode_ff[cvf_pkg::UV_SD_BIT];
   wire logic [1:0] uvh_code = undervoltage_recovery_mode_ff[cvf_pkg::UVH_LSB +: 2];
   wire logic [2:0] uvd_code = undervoltage_recovery_mode_ff[cvf_pkg::UVD_LSB +: 3];

   // illegal cell count code falls back to the smallest pack
   wire logic [3:0] n_cells = (cnt_code == cvf_pkg::CNT_CODE_BAD) ? 4'(cvf_pkg::MIN_CELLS)
                                                                  : 4'(NC - int'(cnt_code));
   wire logic [MV_W-1:0] ov_trip_mv = cvf_pkg::OV_TRIP_BASE_MV
                                      + MV_W'(ovt_code) * cvf_pkg::OV_TRIP_STEP_MV;
   wire logic [MV_W-1:0] ov_hyst_mv = cvf_pkg::OV_HYST_MV[ovh_code];
   wire logic [MV_W-1:0] ov_rel_mv = ov_trip_mv - ov_hyst_mv;
   wire logic [MV_W-1:0] uv_trip_mv = cvf_pkg::UV_TRIP_BASE_MV
                                      + MV_W'(uvt_code) * cvf_pkg::UV_TRIP_STEP_MV;
   wire logic [MV_W-1:0] uv_hyst_mv = MV_W'({1'b0, uvh_code} + 3'h1) * cvf_pkg::UV_HYST_STEP_MV;
   wire logic [MV_W-1:0] uv_sum_mv = uv_trip_mv + uv_hyst_mv;
   wire logic [MV_W-1:0] uv_hys_lvl = (uv_sum_mv > cvf_pkg::UNDERVOLTAGE_RECOVERY_MODE_MAX_MV) ? cvf_pkg::UNDERVOLTAGE_RECOVERY_MODE_MAX_MV
                                                                           : uv_sum_mv;
   wire logic [MV_W-1:0] undervoltage_recovery_mode_mv = uv_inh ? uv_trip_mv : uv_hys_lvl;
   wire logic [3:0] ov_need = 4'(cvf_pkg::OV_DLY_BASE_TICKS) + {1'b0, ovd_code};
   wire logic [7:0] uv_need = 8'(cvf_pkg::UV_DLY_BASE_TICKS) << uvd_code;
   wire logic uv_det_off = (uvd_code == cvf_pkg::UVD_OFF);

   // input synchronisers
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cell_s1_ff <= '0;
         cell_s2_ff <= '0;
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
      end else begin
         cell_s1_ff <= i_cell_mv;
         cell_s2_ff <= cell_s1_ff;
         pin_s1_ff <= i_pins;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // per-cell comparisons, unused cells masked
   logic [NC-1:0] c_ov, c_ovrel, c_uv, c_rec;
   genvar gi;
   generate
      for (gi = 0; gi < NC; gi++) begin : g_cell
         wire logic used = (4'(gi) < n_cells);
         assign c_ov[gi] = used && (cell_s2_ff[gi] > ov_trip_mv);
         assign c_ovrel[gi] = used && (cell_s2_ff[gi] >= ov_rel_mv);
         assign c_uv[gi] = used && (cell_s2_ff[gi] < uv_trip_mv);
         assign c_rec[gi] = used && (cell_s2_ff[gi] <= undervoltage_recovery_mode_mv);
      end
   endgenerate
   wire logic any_ov = |c_ov;
   wire logic all_ov_clear = ~|c_ovrel;
   wire logic any_uv = |c_uv;
   wire logic all_recovered = ~|c_rec;

   // 250 ms timebase
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_cnt_ff <= 24'h000000;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == 24'(TICK_CYCLES - 1)) begin
         tick_cnt_ff <= 24'h000000;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 24'h000001;
         tick_ff <= 1'b0;
      end
   end

   // overvoltage qualification and fault
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ov_cnt_ff <= 4'h0;
      end else if (ov_fault_ff || !any_ov) begin
         ov_cnt_ff <= 4'h0;
      end else if (tick_ff && ov_cnt_ff != 4'hF) begin
         ov_cnt_ff <= ov_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ov_fault_ff <= 1'b0;
      end else if (!ov_fault_ff && any_ov && ov_cnt_ff > ov_need) begin
         ov_fault_ff <= 1'b1;
      end else if (ov_fault_ff && all_ov_clear) begin
         ov_fault_ff <= 1'b0;
      end
   end

   // undervoltage qualification and shutdown hold counters
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         uv_cnt_ff <= 8'h00;
      end else if (uv_st_ff != cvf_pkg::CVF_UV_NORMAL || !any_uv || uv_det_off) begin
         uv_cnt_ff <= 8'h00;
      end else if (tick_ff && uv_cnt_ff != 8'hFF) begin
         uv_cnt_ff <= uv_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         sd_cnt_ff <= 6'h00;
      end else if (uv_st_ff != cvf_pkg::CVF_UV_FAULT || all_recovered) begin
         sd_cnt_ff <= 6'h00;
      end else if (tick_ff && sd_cnt_ff != 6'h3F) begin
         sd_cnt_ff <= sd_cnt_ff + 6'h01;
      end
   end

   // undervoltage state machine
   always_comb begin
      nxt_uv_st = uv_st_ff;
      case (uv_st_ff)
         cvf_pkg::CVF_UV_NORMAL: begin
            if (!uv_det_off && any_uv && uv_cnt_ff > uv_need) begin
               nxt_uv_st = cvf_pkg::CVF_UV_FAULT;
            end
         end
         cvf_pkg::CVF_UV_FAULT: begin
            if (all_recovered && (!undervoltage_recovery_mode_mode || !pin_s2_ff.load_present)) begin
               nxt_uv_st = cvf_pkg::CVF_UV_NORMAL;
            end else if (uv_sd_en && sd_cnt_ff > 6'(cvf_pkg::SD_HOLD_TICKS)) begin
               nxt_uv_st = cvf_pkg::CVF_UV_SHUTDOWN;
            end
         end
         cvf_pkg::CVF_UV_SHUTDOWN: begin
            if (pin_s2_ff.charger_present) begin
               nxt_uv_st = cvf_pkg::CVF_UV_NORMAL;
            end
         end
         default: nxt_uv_st = cvf_pkg::CVF_UV_NORMAL;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         uv_st_ff <= cvf_pkg::CVF_UV_NORMAL;
      end else begin
         uv_st_ff <= nxt_uv_st;
      end
   end

   // switch and thermistor line drive, registered
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         chg_ff <= 1'b0;
         dsg_ff <= 1'b0;
         therm_oe_ff <= 1'b0;
      end else begin
         chg_ff <= !ov_fault_ff && nxt_uv_st == cvf_pkg::CVF_UV_NORMAL;
         dsg_ff <= nxt_uv_st == cvf_pkg::CVF_UV_NORMAL;
         therm_oe_ff <= ts_ctl && ov_fault_ff;
      end
   end

   always_comb begin
      o_rdata = rdata_ff;
      o_ov_fault = ov_fault_ff;
      o_uv_fault = (uv_st_ff == cvf_pkg::CVF_UV_FAULT);
      o_shutdown = (uv_st_ff == cvf_pkg::CVF_UV_SHUTDOWN);
      o_chg_fet_en = chg_ff;
      o_dsg_fet_en = dsg_ff;
      o_therm_out = 1'b0;
      o_therm_oe = therm_oe_ff;
      o_discharge_overcurrent_delay_code = ocd_dly_ff[cvf_pkg::DISCHARGE_OVERCURRENT_DELAY_CODE_W-1:0];
   end

   // checks
   property p_ts_pull;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (ts_ctl && ov_fault_ff) ##1 (ts_ctl && ov_fault_ff) |-> o_therm_oe;
   endproperty
   a_ts_pull: assert property (p_ts_pull) else $error("thermistor line not pulled on ov fault");

   property p_ts_idle;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      o_therm_oe |-> $past(ts_ctl) && $past(ov_fault_ff);
   endproperty
   a_ts_idle: assert property (p_ts_idle) else $error("thermistor line pulled without cause");

   property p_ov_hyst_zero;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (ovh_code == 3'h7) |-> (ov_rel_mv == ov_trip_mv);
   endproperty
   a_ov_hyst_zero: assert property (p_ov_hyst_zero) else $error("ov hysteresis code 7 not zero");

   property p_ov_delay;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      $rose(ov_fault_ff) |-> $past(ov_cnt_ff) == ov_need + 4'h1;
   endproperty
   a_ov_delay: assert property (p_ov_delay) else $error("ov fault set before delay");

   property p_ov_clear;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      $fell(ov_fault_ff) |-> $past(all_ov_clear);
   endproperty
   a_ov_clear: assert property (p_ov_clear) else $error("ov fault cleared above release level");

   property p_inh;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      uv_inh |-> undervoltage_recovery_mode_mv == uv_trip_mv;
   endproperty
   a_inh: assert property (p_inh) else $error("recovery level ignores inhibit");

   property p_rec_load;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (o_uv_fault && undervoltage_recovery_mode_mode && pin_s2_ff.load_present) |=> !(uv_st_ff == cvf_pkg::CVF_UV_NORMAL);
   endproperty
   a_rec_load: assert property (p_rec_load) else $error("uv recovery with load present");

   property p_chg_after_rec;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (o_uv_fault && !ov_fault_ff ##1 uv_st_ff == cvf_pkg::CVF_UV_NORMAL && !ov_fault_ff) |-> o_chg_fet_en;
   endproperty
   a_chg_after_rec: assert property (p_chg_after_rec) else $error("charge not enabled on recovery");

   property p_no_sd;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      $rose(o_shutdown) |-> $past(uv_sd_en) && $past(sd_cnt_ff) == 6'h21;
   endproperty
   a_no_sd: assert property (p_no_sd) else $error("shutdown entered without enable or hold");

   property p_clamp;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      undervoltage_recovery_mode_mv <= cvf_pkg::UNDERVOLTAGE_RECOVERY_MODE_MAX_MV;
   endproperty
   a_clamp: assert property (p_clamp) else $error("uv recovery level above 3.5 V");

   property p_uv_off;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (uv_st_ff == cvf_pkg::CVF_UV_NORMAL && uv_det_off) |=> !o_uv_fault;
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("uv fault with detection off");

   property p_ocd_upper;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_rd && i_addr == cvf_pkg::ADDR_OCD_DLY) |=> o_rdata[7:5] == 3'h0;
   endproperty
   a_ocd_upper: assert property (p_ocd_upper) else $error("discharge_overcurrent_delay upper bits not zero");

   property p_rd_idle;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read answer cycle");

   c_ov_trip: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_ov_fault));
   c_uv_trip: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_uv_fault));
   c_undervoltage_recovery_mode: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $fell(o_uv_fault) && !o_shutdown);
   c_sd: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_shutdown));
endmodule
`default_nettype wire

// [dv/cvf_batt_model.sv]
// behavioural cell stack, charger and load on the far side of the fault block
`default_nettype none
module cvf_batt_model (
   input wire logic i_clk_sys,
   input wire logic i_therm_oe,
   output var cvf_pkg::cvf_cells_t o_cell_mv,
   output var cvf_pkg::cvf_pins_t o_pins,
   output logic o_charging
);
   timeunit 1ns;
   timeprecision 1ns;
   // charger backs off while the thermistor line is pulled low
   assign o_charging = o_pins.charger_present & ~i_therm_oe;
   initial begin
      o_cell_mv = {10{13'h0BB8}};
      o_pins = 2'b00;
   end
   task automatic set_all(input int mv);
      @(posedge i_clk_sys);
      o_cell_mv <= {10{13'(mv)}};
   endtask
   task automatic set_cell(input int idx, input int mv);
      @(posedge i_clk_sys);
      o_cell_mv[idx] <= 13'(mv);
   endtask
   task automatic set_pins(input logic chg, input logic load);
      @(posedge i_clk_sys);
      o_pins <= {chg, load};
   endtask
endmodule
`default_nettype wire

// [dv/cvf_top_test.sv]
// self-checking bench for the cell voltage fault block
`default_nettype none
module cvf_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int T = 4;
   localparam logic [7:0] RSTV [0:6] = '{8'h00, 8'h00, 8'h38, 8'h00, 8'h00, 8'h00, 8'h08};
   localparam logic [7:0] MASK [0:6] = '{8'h00, 8'hFF, 8'h3F, 8'hF7, 8'h8F, 8'hF7, 8'h1F};
   logic i_clk_sys, i_resetn, i_wr, i_rd;
   logic [7:0] i_addr, i_wdata, o_rdata;
   cvf_pkg::cvf_cells_t cell_mv;
   cvf_pkg::cvf_pins_t pins;
   logic o_ov_fault, o_uv_fault, o_shutdown, o_chg_fet_en, o_dsg_fet_en, o_therm_out, o_therm_oe, charging;
   logic [4:0] o_discharge_overcurrent_delay_code;
   logic [2:0] flags;
   int fail_count, samples_checked;
   assign flags = {o_shutdown, o_uv_fault, o_ov_fault};
   cvf_top #(.TICK_CYCLES(T)) DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cell_mv(cell_mv), .i_pins(pins), .o_rdata(o_rdata),
      .o_ov_fault(o_ov_fault), .o_uv_fault(o_uv_fault), .o_shutdown(o_shutdown), .o_chg_fet_en(o_chg_fet_en),
      .o_dsg_fet_en(o_dsg_fet_en), .o_therm_out(o_therm_out), .o_therm_oe(o_therm_oe),
      .o_discharge_overcurrent_delay_code(o_discharge_overcurrent_delay_code));
   cvf_batt_model u_batt (.i_clk_sys(i_clk_sys), .i_therm_oe(o_therm_oe), .o_cell_mv(cell_mv), .o_pins(pins),
      .o_charging(charging));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(16'(o_rdata), 16'(exp));
   endtask
   // counts cycles until a flag reaches v; n must land within lo..hi
   task automatic wait_f(input int idx, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      while (flags[idx] !== v && n <= hi) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      chk(16'(n >= lo && n <= hi), 16'h0001);
   endtask
   task automatic hold_f(input int idx, input logic v, input int k);
      repeat (k) begin
         @(posedge i_clk_sys);
         #1;
         if (flags[idx] !== v) break;
      end
      chk(16'(flags[idx]), 16'(v));
   endtask
   task automatic t_regs();
      for (int a = 1; a <= 6; a++) begin
         rd_chk(8'(a), RSTV[a]);
         wr(8'(a), 8'hFF);
         rd_chk(8'(a), MASK[a]);
      end
      chk(16'(o_discharge_overcurrent_delay_code), 16'h001F);
      wr(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h20, 8'h00);
      for (int a = 1; a <= 6; a++) begin
         wr(8'(a), RSTV[a]);
      end
   endtask
   task automatic t_ov(input logic [2:0] h);
      int hy;
      int trip;
      hy = (h < 6) ? 300 - 50 * h : ((h == 6) ? 25 : 0);
      trip = 2800 + 25 * (24 + 5 * h);
      wr(8'h02, 8'(24 + 5 * h));
      wr(8'h03, {h[0], h, 1'b0, h});
      u_batt.set_cell(2, trip);
      hold_f(0, 1'b0, 4 * T);
      u_batt.set_cell(2, trip + 1);
      wait_f(0, 1'b1, (2 + h) * T, (3 + h) * T + 4);
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk(16'(o_therm_oe), 16'(h[0]));
      chk(16'(charging), 16'(!h[0]));
      chk(16'(o_therm_out), 16'h0000);
      u_batt.set_cell(2, trip - hy);
      hold_f(0, 1'b1, 2 * T);
      u_batt.set_cell(2, trip - hy - 1);
      wait_f(0, 1'b0, 0, 4);
      u_batt.set_cell(2, 3000);
   endtask
   task automatic t_count();
      wr(8'h03, 8'h00);
      wr(8'h01, 8'hC0);
      u_batt.set_cell(4, 4400);
      u_batt.set_cell(5, 0);
      hold_f(0, 1'b0, 6 * T);
      chk(16'(o_uv_fault), 16'h0000);
      u_batt.set_cell(3, 4400);
      wait_f(0, 1'b1, 2 * T, 3 * T + 4);
      u_batt.set_all(3000);
      wait_f(0, 1'b0, 0, 4);
      wr(8'h01, 8'h00);
   endtask
   task automatic t_uv(input logic [3:0] u, input logic [1:0] h, input logic inh, input logic mode,
                       input logic [2:0] d);
      int trip;
      int rec;
      trip = 1400 + 100 * u;
      rec = (trip + 400 * (h + 1) > 3500) ? 3500 : trip + 400 * (h + 1);
      rec = inh ? trip : rec;
      wr(8'h04, {inh, 3'h0, u});
      wr(8'h05, {mode, 1'b0, h, 1'b0, d});
      u_batt.set_pins(!mode, mode);
      u_batt.set_cell(9, trip);
      hold_f(1, 1'b0, 4 * T);
      u_batt.set_cell(9, trip - 1);
      wait_f(1, 1'b1, (2 << d) * T, ((2 << d) + 1) * T + 4);
      hold_f(1, 1'b1, 2);
      chk(16'({o_chg_fet_en, o_dsg_fet_en}), 16'h0000);
      u_batt.set_all(rec);
      hold_f(1, 1'b1, 2 * T);
      u_batt.set_all(rec + 1);
      if (mode) begin
         hold_f(1, 1'b1, 2 * T);
         u_batt.set_pins(1'b0, 1'b0);
      end
      wait_f(1, 1'b0, 0, 4);
      hold_f(1, 1'b0, 2);
      chk(16'(o_chg_fet_en), 16'h0001);
      u_batt.set_all(3000);
   endtask
   task automatic t_sd();
      u_batt.set_pins(1'b0, 1'b0);
      wr(8'h05, 8'h07);
      u_batt.set_cell(9, 1000);
      hold_f(1, 1'b0, 40 * T);
      wr(8'h05, 8'h00);
      wait_f(1, 1'b1, 0, 3 * T + 6);
      rd_chk(8'h10, 8'h02);
      hold_f(2, 1'b0, 40 * T);
      u_batt.set_all(3000);
      wait_f(1, 1'b0, 0, 4);
      wr(8'h05, 8'h40);
      u_batt.set_cell(9, 1000);
      wait_f(1, 1'b1, 2 * T, 3 * T + 4);
      wait_f(2, 1'b1, 32 * T, 33 * T + 4);
      u_batt.set_all(3000);
      u_batt.set_pins(1'b1, 1'b0);
      wait_f(2, 1'b0, 0, 6);
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      $display("Error at %0t: run did not finish", $time);
      fail_count++;
      stop_test();
   end
   initial begin
      i_resetn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      repeat (20) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      t_regs();
      u_batt.set_pins(1'b1, 1'b0);
      for (int h = 0; h < 8; h++) begin
         t_ov(3'(h));
      end
      wr(8'h02, 8'h38);
      t_count();
      t_uv(4'h0, 2'h0, 1'b0, 1'b0, 3'h0);
      t_uv(4'hF, 2'h3, 1'b0, 1'b1, 3'h1);
      t_uv(4'h5, 2'h3, 1'b0, 1'b0, 3'h2);
      t_uv(4'h2, 2'h1, 1'b1, 1'b1, 3'h0);
      t_uv(4'h9, 2'h2, 1'b0, 1'b0, 3'h0);
      t_sd();
      stop_test();
   end
endmodule
`default_nettype wire
